// ===== rtl/lsmc_bank.sv
// lock status and misc control register bank
`timescale 1ns/1ps
module lsmc_bank
  import lsmc_pkg::*;
(
  input  wire logic          clk_i,          // configuration clock, 50 MHz
  input  wire logic          rst_n_i,        // async reset, active low
  input  wire lsmc_req_type  req_i,          // register access from serial port
  output logic [7:0]         rdata_o,        // read data, registered
  input  wire logic [4:0]    pin1_source_i,  // first pin source field
  input  wire logic          loop2_detect_force_on_i, // force loop2 detector on
  input  wire logic          lock1_i,        // loop1 digital lock detect
  input  wire logic          lock2_i,        // loop2 digital lock detect
  input  wire lsmc_src_type  src_i,          // other routable signals
  output lsmc_pin_type       second_status_pin_o, // pin drive and enable_n
  output lsmc_ctrl_type      ctrl_o          // power-down and hold controls
);

  typedef struct packed {
    logic [4:0] src;
    logic [2:0] dtype;
    logic       pre_pd;
    logic       loop2_pd;
    logic       ext_pd;
    logic       hold;
    logic       clr1;
    logic       clr2;
    logic       lost1;
    logic       lost2;
    logic       lock1_prev;
    logic       lock2_prev;
    logic [7:0] rdata;
  } lsmc_state_type;

  lsmc_state_type state_reg;
  lsmc_state_type state_next;
  logic           fall1;
  logic           fall2;
  logic           detect2_run;

  localparam lsmc_state_type STATE_RST = '{
    src: SRC_RST, dtype: TYPE_RST, pre_pd: PD_RST, loop2_pd: PD_RST, ext_pd: PD_RST,
    hold: 1'b0, clr1: 1'b0, clr2: 1'b0, lost1: 1'b0, lost2: 1'b0,
    lock1_prev: 1'b0, lock2_prev: 1'b0, rdata: 8'h00};

  // loop2 detector idles unless forced or routed to a pin
  assign detect2_run = loop2_detect_force_on_i | is_loop2_route(state_reg.src)
                       | is_loop2_route(pin1_source_i); // RULE14

  // the edge detectors track the live level even while cleared, so a release
  // while already low finds no edge
  assign fall1 = state_reg.lock1_prev & ~lock1_i; // RULE8 RULE10
  assign fall2 = state_reg.lock2_prev & ~lock2_i & detect2_run; // RULE9 RULE10

  always_comb begin
    state_next            = state_reg;
    state_next.lock1_prev = lock1_i;
    state_next.lock2_prev = lock2_i & detect2_run;

    if (req_i.wr) begin
      case (req_i.addr)
        OFS_PIN2_CFG: begin
          state_next.src   = req_i.wdata[SRC_LSB +: 5];
          state_next.dtype = req_i.wdata[TYPE_LSB +: 3];
        end
        OFS_PWRDN: begin
          state_next.pre_pd   = req_i.wdata[PRE_PD_BIT]; // RULE4
          state_next.loop2_pd = req_i.wdata[LOOP2_PD_BIT];
          state_next.ext_pd   = req_i.wdata[EXT_PD_BIT];
        end
        OFS_RDIV_HOLD: state_next.hold = req_i.wdata[HOLD_BIT]; // RULE5
        OFS_LOST_CLR: begin
          state_next.clr1 = req_i.wdata[CLR1_BIT];
          state_next.clr2 = req_i.wdata[CLR2_BIT];
        end
        default: ; // readback and unmapped writes are dropped RULE15
      endcase
    end

    // clear held high wins over the edge by definition of the held-clear bit
    if (state_reg.clr1) begin
      state_next.lost1 = 1'b0; // RULE7
    end else if (fall1) begin
      state_next.lost1 = 1'b1; // RULE8
    end
    if (state_reg.clr2) begin
      state_next.lost2 = 1'b0; // RULE7
    end else if (fall2) begin
      state_next.lost2 = 1'b1; // RULE9
    end

    if (req_i.rd) begin
      case (req_i.addr)
        OFS_PIN2_CFG:  state_next.rdata = {state_reg.src, state_reg.dtype};
        OFS_PWRDN: begin
          state_next.rdata               = 8'h00; // RULE15
          state_next.rdata[PRE_PD_BIT]   = state_reg.pre_pd;
          state_next.rdata[LOOP2_PD_BIT] = state_reg.loop2_pd;
          state_next.rdata[EXT_PD_BIT]   = state_reg.ext_pd;
        end
        OFS_RDIV_HOLD: begin
          state_next.rdata           = 8'h00;
          state_next.rdata[HOLD_BIT] = state_reg.hold;
        end
        OFS_LOST_CLR: begin
          state_next.rdata           = 8'h00;
          state_next.rdata[CLR1_BIT] = state_reg.clr1;
          state_next.rdata[CLR2_BIT] = state_reg.clr2;
        end
        OFS_LOCK_RB: begin
          state_next.rdata               = 8'h00;
          state_next.rdata[RB_LOST1_BIT] = state_reg.lost1;
          state_next.rdata[RB_LIVE1_BIT] = lock1_i; // RULE11
          state_next.rdata[RB_LOST2_BIT] = state_reg.lost2;
          // reads low while the loop2 detector is idle RULE12
          state_next.rdata[RB_LIVE2_BIT] = lock2_i & detect2_run;
        end
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o                 = state_reg.rdata;
  assign ctrl_o.prescaler_pd     = state_reg.pre_pd;
  assign ctrl_o.loop2_pd         = state_reg.loop2_pd;
  assign ctrl_o.ext_input_pd     = state_reg.ext_pd;
  assign ctrl_o.ref_div_hold     = state_reg.hold;
  assign ctrl_o.loop2_detect_run = detect2_run;

  lsmc_pin_drive u_pin_drive (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .source_i (state_reg.src),
    .type_i   (state_reg.dtype),
    .lock1_i  (lock1_i),
    .lock2_i  (lock2_i & detect2_run),
    .src_i    (src_i),
    .pin_o    (second_status_pin_o)
  );

endmodule : lsmc_bank

// ===== rtl/lsmc_pin_drive.sv
// second status pin source mux and drive type
`timescale 1ns/1ps
module lsmc_pin_drive
  import lsmc_pkg::*;
(
  input  wire logic          clk_i,     // configuration clock
  input  wire logic          rst_n_i,   // async reset, active low
  input  wire logic [4:0]    source_i,  // pin source field
  input  wire logic [2:0]    type_i,    // pin drive type field
  input  wire logic          lock1_i,   // loop1 lock detect
  input  wire logic          lock2_i,   // loop2 lock detect
  input  wire lsmc_src_type  src_i,     // other routable signals
  output lsmc_pin_type       pin_o      // pin output and enable
);

  typedef struct packed {
    logic [3:0]   div_prev;
    logic [3:0]   half;
    lsmc_pin_type pin;
  } lsmc_drv_state_type;

  lsmc_drv_state_type state_reg;
  lsmc_drv_state_type state_next;
  logic               level;

  always_comb begin
    state_next          = state_reg;
    state_next.div_prev = src_i.div_out;
    // halved divider outputs toggle on each rising edge of the straight output
    for (int i = 0; i < 4; i++) begin
      if (src_i.div_out[i] && !state_reg.div_prev[i]) begin
        state_next.half[i] = ~state_reg.half[i];
      end
    end
    case (source_i) // RULE1
      SRC_LOW:         level = 1'b0;
      SRC_LOOP1_LOCK:  level = lock1_i;
      SRC_LOOP2_LOCK:  level = lock2_i;
      SRC_BOTH_LOCK:   level = lock1_i & lock2_i;
      SRC_HOLDOVER:    level = src_i.holdover;
      SRC_DAC_LOCKED:  level = src_i.dac_locked;
      SRC_READBACK:    level = src_i.readback;
      SRC_DAC_RAIL:    level = src_i.dac_rail;
      SRC_DAC_LOW:     level = src_i.dac_low;
      SRC_DAC_HIGH:    level = src_i.dac_high;
      SRC_L1_FB:       level = src_i.div_out[3];
      SRC_L1_FB_HALF:  level = state_reg.half[3];
      SRC_L2_FB:       level = src_i.div_out[2];
      SRC_L2_FB_HALF:  level = state_reg.half[2];
      SRC_L1_REF:      level = src_i.div_out[1];
      SRC_L1_REF_HALF: level = state_reg.half[1];
      SRC_L2_REF:      level = src_i.div_out[0];
      SRC_L2_REF_HALF: level = state_reg.half[0];
      default:         level = 1'b0;
    endcase
    case (type_i) // RULE2
      TYPE_PUSH_PULL: begin
        state_next.pin.o    = level;
        state_next.pin.oe_n = 1'b0;
      end
      TYPE_PUSH_INV: begin
        state_next.pin.o    = ~level;
        state_next.pin.oe_n = 1'b0;
      end
      TYPE_OPEN_DRAIN: begin
        // only pull low; released high is left to the board
        state_next.pin.o    = 1'b0;
        state_next.pin.oe_n = level;
      end
      default: begin
        // reserved types leave the pin undriven
        state_next.pin.o    = 1'b0;
        state_next.pin.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '{div_prev: 4'h0, half: 4'h0, pin: '{o: 1'b0, oe_n: 1'b1}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_o = state_reg.pin;

endmodule : lsmc_pin_drive

// ===== rtl/lsmc_pkg.sv
// package: register map, field layout, encodings and carriers for the lock status and misc control bank
// Overview of operation
// RULE1: bits 7:3 of the pin2 config register pick which internal signal drives the second status pin, reset 0, codes 0..18.
// RULE2: bits 2:0 of the pin2 config register pick the drive type of the second status pin, reset 6; 3 push-pull, 4 inverted, 6 open drain.
// RULE3: software selects the loop2 reference divider outputs (17, 18) only while the first pin source is neither 2 nor 3.
// RULE4: prescaler, second loop and external input power-down bits 6, 5, 4 reset to 1 and power the unit down while 1.
// RULE5: while the hold bit 5 is 1 the first loop reference divider is kept in reset.
// RULE6: software clears a lost flag by writing 1 then 0 to its clear bit, bit 1 for loop1 and bit 0 for loop2.
// RULE7: while a clear bit is 1 its lost flag is forced to 0 and cannot set.
// RULE8: a falling edge of the loop1 lock detect sets the sticky loop1 lost flag in readback bit 3.
// RULE9: a falling edge of the loop2 lock detect sets the sticky loop2 lost flag in readback bit 1.
// RULE10: releasing a clear while lock detect is already low does not set the flag; only a later falling edge does.
// RULE11: readback bit 2 shows the live loop1 lock detect level.
// RULE12: readback bit 0 shows the live loop2 lock detect level, valid only when a pin routes the loop2 lock or the force-on bit is 1.
// RULE13: software routes loop2 lock or combined lock to a pin, or sets the force-on bit, for valid loop2 readback.
// RULE14: the loop2 detector runs while the force-on bit is 1 or while a status pin routes the loop2 lock.
// RULE15: the readback register ignores writes and reserved bits read as zero.
package lsmc_pkg;

  localparam int unsigned ADDR_W = 13;

  localparam logic [12:0] OFS_PIN2_CFG   = 13'h016e;
  localparam logic [12:0] OFS_PWRDN      = 13'h0173;
  localparam logic [12:0] OFS_RDIV_HOLD  = 13'h0177;
  localparam logic [12:0] OFS_LOST_CLR   = 13'h0182;
  localparam logic [12:0] OFS_LOCK_RB    = 13'h0183;

  // field positions
  localparam int unsigned SRC_LSB        = 3;
  localparam int unsigned TYPE_LSB       = 0;
  localparam int unsigned PRE_PD_BIT     = 6;
  localparam int unsigned LOOP2_PD_BIT   = 5;
  localparam int unsigned EXT_PD_BIT     = 4;
  localparam int unsigned HOLD_BIT       = 5;
  localparam int unsigned CLR1_BIT       = 1;
  localparam int unsigned CLR2_BIT       = 0;
  localparam int unsigned RB_LOST1_BIT   = 3;
  localparam int unsigned RB_LIVE1_BIT   = 2;
  localparam int unsigned RB_LOST2_BIT   = 1;
  localparam int unsigned RB_LIVE2_BIT   = 0;

  // reset values
  localparam logic [4:0] SRC_RST         = 5'h00;
  localparam logic [2:0] TYPE_RST        = 3'h6;
  localparam logic       PD_RST          = 1'b1;

  // source codes
  localparam logic [4:0] SRC_LOW         = 5'h00;
  localparam logic [4:0] SRC_LOOP1_LOCK  = 5'h01;
  localparam logic [4:0] SRC_LOOP2_LOCK  = 5'h02;
  localparam logic [4:0] SRC_BOTH_LOCK   = 5'h03;
  localparam logic [4:0] SRC_HOLDOVER    = 5'h04;
  localparam logic [4:0] SRC_DAC_LOCKED  = 5'h05;
  localparam logic [4:0] SRC_READBACK    = 5'h07;
  localparam logic [4:0] SRC_DAC_RAIL    = 5'h08;
  localparam logic [4:0] SRC_DAC_LOW     = 5'h09;
  localparam logic [4:0] SRC_DAC_HIGH    = 5'h0a;
  localparam logic [4:0] SRC_L1_FB       = 5'h0b;
  localparam logic [4:0] SRC_L1_FB_HALF  = 5'h0c;
  localparam logic [4:0] SRC_L2_FB       = 5'h0d;
  localparam logic [4:0] SRC_L2_FB_HALF  = 5'h0e;
  localparam logic [4:0] SRC_L1_REF      = 5'h0f;
  localparam logic [4:0] SRC_L1_REF_HALF = 5'h10;
  localparam logic [4:0] SRC_L2_REF      = 5'h11;
  localparam logic [4:0] SRC_L2_REF_HALF = 5'h12;

  // drive types
  localparam logic [2:0] TYPE_PUSH_PULL  = 3'h3;
  localparam logic [2:0] TYPE_PUSH_INV   = 3'h4;
  localparam logic [2:0] TYPE_OPEN_DRAIN = 3'h6;

  localparam int unsigned NUM_TAPS       = 8;

  // internal signals that may be routed to the pin
  typedef struct packed {
    logic       holdover;
    logic       dac_locked;
    logic       readback;
    logic       dac_rail;
    logic       dac_low;
    logic       dac_high;
    logic [3:0] div_out;  // loop1 fb, loop2 fb, loop1 ref, loop2 ref
  } lsmc_src_type;

  typedef struct packed {
    logic prescaler_pd;
    logic loop2_pd;
    logic ext_input_pd;
    logic ref_div_hold;
    logic loop2_detect_run;
  } lsmc_ctrl_type;

  typedef struct packed {
    logic o;
    logic oe_n;
  } lsmc_pin_type;

  // register read and write port
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [12:0]       addr;
    logic [7:0]        wdata;
  } lsmc_req_type;

  function automatic logic is_loop2_route(input logic [4:0] sel);
    return (sel == SRC_LOOP2_LOCK) || (sel == SRC_BOTH_LOCK);
  endfunction : is_loop2_route

endpackage : lsmc_pkg

// ===== test/lsmc_bank_asserts.sv
// concurrent checks on the ports of the lock status and misc control bank
`timescale 1ns/1ps
module lsmc_bank_chk
  import lsmc_pkg::*;
(
  input wire logic          clk_i,                   // clock
  input wire logic          rst_n_i,                 // reset, active low
  input wire lsmc_req_type  req_i,                   // register access
  input wire logic [7:0]    rdata_o,                 // read data
  input wire logic [4:0]    pin1_source_i,           // first pin source
  input wire logic          loop2_detect_force_on_i, // detector force-on
  input wire logic          lock1_i,                 // loop1 lock detect
  input wire lsmc_pin_type  second_status_pin_o,     // pin drive
  input wire lsmc_ctrl_type ctrl_o                   // controls
);
  logic [7:0] cfg_reg;
  logic [1:0] clr_reg;
  wire logic  rd_rb = req_i.rd && (req_i.addr == OFS_LOCK_RB);
  wire logic  rd_bad = req_i.rd && !(req_i.addr inside {OFS_PIN2_CFG, OFS_PWRDN, OFS_RDIV_HOLD, OFS_LOST_CLR,
                                                         OFS_LOCK_RB});

  // shadows of the pin config and clear bits, so pin and flag checks know the setting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= 8'h06;
      clr_reg <= 2'h0;
    end else if (req_i.wr && req_i.addr == OFS_PIN2_CFG) begin
      cfg_reg <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == OFS_LOST_CLR) begin
      clr_reg <= req_i.wdata[1:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pd_write: assert property (
    req_i.wr && req_i.addr == OFS_PWRDN |=> ctrl_o[4:2] == $past(req_i.wdata[6:4]))
    else $error("power-down bits do not follow the write");
  a_hold_write: assert property (
    req_i.wr && req_i.addr == OFS_RDIV_HOLD |=> ctrl_o.ref_div_hold == $past(req_i.wdata[5]))
    else $error("divider hold does not follow the write");
  a_ctrl_keep: assert property (
    !req_i.wr |=> $stable(ctrl_o[4:1])) else $error("controls changed without a write");
  a_live_lock1: assert property (
    rd_rb && $stable(lock1_i) |=> rdata_o[2] == $past(lock1_i)) else $error("live loop1 lock bit wrong");
  a_rb_reserved: assert property (
    rd_rb |=> rdata_o[7:4] == 4'h0) else $error("reserved readback bits not zero");
  a_unmapped_rd: assert property (
    rd_bad |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_detect_run: assert property (
    loop2_detect_force_on_i || pin1_source_i inside {5'h02, 5'h03} || cfg_reg[7:3] inside {5'h02, 5'h03}
    |-> ctrl_o.loop2_detect_run) else $error("loop2 detector not running");
  a_pin_undriven: assert property (
    !(cfg_reg[2:0] inside {3'h3, 3'h4, 3'h6}) |=> second_status_pin_o.oe_n) else $error("reserved type drives pin");
  a_pin_lock1: assert property (
    cfg_reg[7:3] == SRC_LOOP1_LOCK && cfg_reg[2:0] inside {3'h3, 3'h4} && $stable(lock1_i)
    |=> !second_status_pin_o.oe_n && second_status_pin_o.o == ($past(lock1_i) ^ $past(cfg_reg[2])))
    else $error("push-pull pin does not show loop1 lock");
  a_od_low: assert property (
    cfg_reg == 8'h06 |=> !second_status_pin_o.oe_n) else $error("open drain low level not driven");
  a_clear_held: assert property (
    rd_rb && clr_reg[1] && $past(clr_reg[1]) |=> !rdata_o[3]) else $error("loop1 flag set while clear held");
  a_live2_idle: assert property (
    rd_rb && !ctrl_o.loop2_detect_run |=> !rdata_o[0]) else $error("loop2 live bit high while detector idle");

  c_flag_seen: cover property (rd_rb ##1 rdata_o[3]);
  c_inverted: cover property (cfg_reg[2:0] == 3'h4);
  c_forced: cover property (loop2_detect_force_on_i && ctrl_o.loop2_detect_run);
endmodule : lsmc_bank_chk

bind lsmc_bank lsmc_bank_chk u_chk (.clk_i, .rst_n_i, .req_i, .rdata_o, .pin1_source_i,
  .loop2_detect_force_on_i, .lock1_i, .second_status_pin_o, .ctrl_o);

// ===== test/tb_lock_status_and_misc_control.sv
// self-checking bench for the lock status and misc control bank
`timescale 1ns/1ps
module tb_lock_status_and_misc_control
  import lsmc_pkg::*;
;
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  lsmc_req_type  req = '0;
  logic [7:0]    rdata;
  logic [4:0]    pin1_src = 5'h00;
  logic          force_on = 1'b0;
  logic          lock1 = 1'b0;
  logic          lock2 = 1'b0;
  lsmc_src_type  src = '0;
  lsmc_pin_type  pin;
  lsmc_ctrl_type ctrl;
  logic [7:0]    exp_q[$];
  logic          pend = 1'b0;
  int            err_count = 0;
  int            n_compared = 0;
  int            cycles = 0;

  lsmc_bank uut (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .req_i                   (req),
    .rdata_o                 (rdata),
    .pin1_source_i           (pin1_src),
    .loop2_detect_force_on_i (force_on),
    .lock1_i                 (lock1),
    .lock2_i                 (lock2),
    .src_i                   (src),
    .second_status_pin_o     (pin),
    .ctrl_o                  (ctrl)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one access per call; the idle edge after it keeps strobes from being set twice in one step
  task automatic bus(input logic wr, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req.wr    <= wr;
    req.rd    <= !wr;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk_i);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask : bus

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic setl(input logic a, input logic b);
    @(posedge clk_i);
    lock1 <= a;
    lock2 <= b;
    repeat (3) @(posedge clk_i);
  endtask : setl

  // read data shows one cycle after the edge that takes the read
  always @(posedge clk_i) begin
    if (pend) begin
      check("rdata", rdata, exp_q.pop_front());
    end
    pend <= req.rd;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    logic [7:0]  d;
    logic        l;
    logic [18:0] m;
    void'($urandom(72));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_PIN2_CFG, 8'h06);
    rd(OFS_PWRDN, 8'h70);
    rd(OFS_RDIV_HOLD, 8'h00);
    rd(OFS_LOST_CLR, 8'h00);
    rd(OFS_LOCK_RB, 8'h00);
    check("ctrl", {4'h0, ctrl[4:1]}, 8'h0e);
    check("pin_oe_n", {7'h0, pin.oe_n}, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      bus(1'b1, OFS_PWRDN, d);
      rd(OFS_PWRDN, d & 8'h70);
      check("ctrl_pd", {5'h0, ctrl[4:2]}, {5'h0, d[6:4]});
      bus(1'b1, OFS_RDIV_HOLD, d);
      rd(OFS_RDIV_HOLD, d & 8'h20);
      check("ctrl_hold", {7'h0, ctrl.ref_div_hold}, {7'h0, d[5]});
      bus(1'b1, OFS_PIN2_CFG, d);
      rd(OFS_PIN2_CFG, d);
      bus(1'b1, OFS_LOCK_RB, d);
      rd(OFS_LOCK_RB, 8'h00);
      bus(1'b1, 13'h0190, d);
      rd(13'h0190, 8'h00);
    end
    $display("test register access done");
    bus(1'b1, OFS_PIN2_CFG, 8'h06);
    @(posedge clk_i);
    pin1_src <= SRC_LOOP2_LOCK;
    setl(1'b1, 1'b1);
    rd(OFS_LOCK_RB, 8'h05);
    setl(1'b0, 1'b0);
    rd(OFS_LOCK_RB, 8'h0a);
    bus(1'b1, OFS_LOST_CLR, 8'h03);
    rd(OFS_LOCK_RB, 8'h00);
    setl(1'b1, 1'b1);
    setl(1'b0, 1'b0);
    rd(OFS_LOCK_RB, 8'h00);
    bus(1'b1, OFS_LOST_CLR, 8'h00);
    rd(OFS_LOCK_RB, 8'h00);
    setl(1'b1, 1'b1);
    setl(1'b0, 1'b0);
    bus(1'b1, OFS_LOST_CLR, 8'h02);
    rd(OFS_LOCK_RB, 8'h02);
    bus(1'b1, OFS_LOST_CLR, 8'h01);
    bus(1'b1, OFS_LOST_CLR, 8'h00);
    @(posedge clk_i);
    pin1_src <= SRC_LOW;
    setl(1'b0, 1'b1);
    check("detect_run", {7'h0, ctrl.loop2_detect_run}, 8'h00);
    setl(1'b0, 1'b0);
    rd(OFS_LOCK_RB, 8'h00);
    @(posedge clk_i);
    force_on <= 1'b1;
    setl(1'b0, 1'b1);
    rd(OFS_LOCK_RB, 8'h01);
    check("detect_run", {7'h0, ctrl.loop2_detect_run}, 8'h01);
    @(posedge clk_i);
    force_on <= 1'b0;
    $display("test lost flags done");
    // halved divider codes are left out: their phase depends on divider history
    for (int s = 0; s < 19; s++) begin
      if (s inside {12, 14, 16, 18}) continue;
      for (int t = 0; t < 8; t++) begin
        @(posedge clk_i);
        src   <= 10'($urandom);
        lock1 <= 1'($urandom);
        lock2 <= 1'($urandom);
        bus(1'b1, OFS_PIN2_CFG, {s[4:0], t[2:0]});
        repeat (2) @(posedge clk_i);
        m = {1'b0, src.div_out[0], 1'b0, src.div_out[1], 1'b0, src.div_out[2], 1'b0, src.div_out[3],
             src.dac_high, src.dac_low, src.dac_rail, src.readback, 1'b0, src.dac_locked, src.holdover,
             lock1 & lock2, lock2, lock1, 1'b0};
        l = m[s];
        check("pin_oe_n", {7'h0, pin.oe_n}, (t == 3 || t == 4) ? 8'h00 : (t == 6) ? {7'h0, l} : 8'h01);
        if (t == 3 || t == 4) check("pin_o", {7'h0, pin.o}, {7'h0, l ^ (t == 4)});
      end
    end
    $display("test pin routing done");
    // each rising edge of the straight divider output flips its halved copy
    for (int s = 12; s < 19; s += 2) begin
      bus(1'b1, OFS_PIN2_CFG, {s[4:0], TYPE_PUSH_PULL});
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_i);
        src.div_out <= 4'h0;
        repeat (2) @(posedge clk_i);
        l = pin.o;
        @(posedge clk_i);
        src.div_out <= 4'hf;
        repeat (3) @(posedge clk_i);
        check("pin_half", {7'h0, pin.o}, {7'h0, ~l});
      end
    end
    $display("test halved dividers done");
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule : tb_lock_status_and_misc_control
